/* hdl/dtc_timer.sv */
`timescale 1ns/1ps
module dtc_timer (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Control
  input  wire dtc_pkg::dtc_ctrl_type ctrl_zero_in,
  input  wire dtc_pkg::dtc_ctrl_type ctrl_one_in,
  input  wire logic                  split_run_in,
  // Pins
  input  wire logic                  ext_irq_in_zero,
  input  wire logic                  ext_irq_in_one,
  // Counts and overflow flags
  output dtc_pkg::dtc_count_type     count_zero_out,
  output dtc_pkg::dtc_count_type     count_one_out,
  output logic                       ovf_zero_out,
  output logic                       ovf_one_out,
  output logic                       ovf_split_out
);
  logic [3:0]             div;
  logic                   mcyc;
  logic [1:0]             irq0_sync;
  logic [1:0]             irq1_sync;
  logic [4:0]             pre0;
  logic [4:0]             pre1;
  dtc_pkg::dtc_count_type cnt0;
  dtc_pkg::dtc_count_type cnt1;
  logic                   ovf0;
  logic                   ovf1;
  logic                   ovfs;

  function automatic logic gate_ok(input dtc_pkg::dtc_ctrl_type c,
                                   input logic lvl);
    gate_ok = c.run && (!c.gate_enable || lvl);
  endfunction : gate_ok

  // Next count and overflow for one timer; split forces 8-bit low-byte use.
  // Result packs {high, low, overflow, prescaler} as 8+8+1+5 bits
  function automatic logic [21:0] step(input dtc_pkg::dtc_count_type c,
                                       input dtc_pkg::dtc_mode_type m,
                                       input logic [4:0] p);
    logic [8:0] lo;
    logic [8:0] hi;
    lo = {1'b0, c.low} + 9'h001;
    hi = {1'b0, c.high} + 9'h001;
    step = {c, 1'b0, p};
    unique case (m)
      dtc_pkg::DTC_MODE_PRE8: begin
        if (p == dtc_pkg::DTC_PRE_LAST) begin
          step = {hi[7:0], c.low, hi[8], 5'h00};
        end else begin
          step = {c, 1'b0, 5'(p + 5'h01)};
        end
      end
      dtc_pkg::DTC_MODE_CNT16: begin
        if (lo[8]) begin
          step = {hi[7:0], 8'h00, hi[8], p};
        end else begin
          step = {c.high, lo[7:0], 1'b0, p};
        end
      end
      dtc_pkg::DTC_MODE_AUTO8: begin
        if (lo[8]) begin
          step = {c.high, c.high, 1'b1, p};
        end else begin
          step = {c.high, lo[7:0], 1'b0, p};
        end
      end
      dtc_pkg::DTC_MODE_SPLIT: begin
        step = {c.high, lo[7:0], lo[8], p};
      end
    endcase
  endfunction : step

  wire        run0   = mcyc && gate_ok(ctrl_zero_in, irq0_sync[1]);
  wire        run1   = mcyc && gate_ok(ctrl_one_in, irq1_sync[1])
                       && ctrl_one_in.mode != dtc_pkg::DTC_MODE_SPLIT;
  wire        split0 = ctrl_zero_in.mode == dtc_pkg::DTC_MODE_SPLIT;
  wire        run0h  = mcyc && split0 && split_run_in;
  wire [21:0] nx0    = step(cnt0, ctrl_zero_in.mode, pre0);
  wire [21:0] nx1    = step(cnt1, ctrl_one_in.mode, pre1);
  wire [8:0]  hi0inc = {1'b0, cnt0.high} + 9'h001;
  // Split high half counts on its own run input and ignores the gate pin
  wire [7:0]  next_hi0  = run0h ? hi0inc[7:0] : nx0[21:14];
  wire [7:0]  next_lo0  = nx0[13:6];
  wire        next_ovf0 = nx0[5];
  wire [4:0]  next_pre0 = nx0[4:0];
  wire [15:0] next_cnt1 = nx1[21:6];
  wire        next_ovf1 = nx1[5];
  wire [4:0]  next_pre1 = nx1[4:0];

  // One machine cycle is twelve clocks; mcyc is the only count enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div  <= dtc_pkg::DTC_DIV_RESET;
      mcyc <= 1'b0;
    end else begin
      mcyc <= div == dtc_pkg::DTC_MCYC_LAST;
      div  <= (div == dtc_pkg::DTC_MCYC_LAST) ? 4'h0 : div + 4'h1;
    end
  end

  // Gate pins are asynchronous; two flops before the gate logic reads them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq0_sync <= 2'b00;
      irq1_sync <= 2'b00;
    end else begin
      irq0_sync <= {irq0_sync[0], ext_irq_in_zero};
      irq1_sync <= {irq1_sync[0], ext_irq_in_one};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt0 <= {dtc_pkg::DTC_BYTE_RESET, dtc_pkg::DTC_BYTE_RESET};
      pre0 <= dtc_pkg::DTC_PRE_RESET;
      ovf0 <= 1'b0;
      ovfs <= 1'b0;
    end else begin
      ovf0 <= run0 && next_ovf0;
      ovfs <= run0h && hi0inc[8];
      if (run0) begin
        cnt0.low <= next_lo0;
        pre0     <= next_pre0;
      end
      if (run0 || run0h) begin
        cnt0.high <= next_hi0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt1 <= {dtc_pkg::DTC_BYTE_RESET, dtc_pkg::DTC_BYTE_RESET};
      pre1 <= dtc_pkg::DTC_PRE_RESET;
      ovf1 <= 1'b0;
    end else begin
      ovf1 <= run1 && next_ovf1;
      if (run1) begin
        cnt1 <= next_cnt1;
        pre1 <= next_pre1;
      end
    end
  end

  assign count_zero_out = cnt0;
  assign count_one_out  = cnt1;
  assign ovf_zero_out   = ovf0;
  assign ovf_one_out    = ovf1;
  assign ovf_split_out  = ovfs;

  // Assertions rest while reset is high; counters sit at zero then

  a_mcyc_spacing: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mcyc |=> !mcyc [*8] ##1 !mcyc [*3] ##1 mcyc)
    else $error("machine cycle pulse not every twelve clocks");

  a_idle_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !mcyc |=> $stable(cnt0) && $stable(cnt1))
    else $error("count moved outside a machine cycle");

  a_ovf_pulse: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ovf0 || ovf1 || ovfs |=> !ovf0 && !ovf1 && !ovfs)
    else $error("overflow pulse longer than one clock");

  a_cnt16_step: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run0 && ctrl_zero_in.mode == dtc_pkg::DTC_MODE_CNT16
    |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("16-bit count did not advance by one");

  a_pre_wrap: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run1 && ctrl_one_in.mode == dtc_pkg::DTC_MODE_PRE8
    && pre1 != dtc_pkg::DTC_PRE_LAST |=> $stable(cnt1.high))
    else $error("prescaled count moved before prescaler wrapped");

  a_pre_carry: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run1 && ctrl_one_in.mode == dtc_pkg::DTC_MODE_PRE8
    && pre1 == dtc_pkg::DTC_PRE_LAST
    |=> cnt1.high == $past(cnt1.high) + 8'h01)
    else $error("prescaled count missed a prescaler wrap");

  a_auto_reload: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run0 && ctrl_zero_in.mode == dtc_pkg::DTC_MODE_AUTO8
    && cnt0.low == 8'hFF |=> cnt0.low == $past(cnt0.high) && ovf0)
    else $error("reload missing on low byte overflow");

  a_auto_high: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ctrl_one_in.mode == dtc_pkg::DTC_MODE_AUTO8
    |=> $stable(cnt1.high))
    else $error("reload value changed in reload mode");

  a_split_stop: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ctrl_one_in.mode == dtc_pkg::DTC_MODE_SPLIT |=> $stable(cnt1))
    else $error("timer 1 counted in split mode");

  a_split_low: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run0 && split0 |=> cnt0.low == $past(cnt0.low) + 8'h01)
    else $error("split low half did not advance by one");

  a_split_high: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run0h |=> cnt0.high == $past(cnt0.high) + 8'h01)
    else $error("split high half did not advance by one");

  a_split_ovf: assert property (
    @(posedge clk_in) disable iff (rst_in)
    run0h && cnt0.high == 8'hFF |=> ovfs)
    else $error("split high half wrapped without its flag");

  a_gate_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ctrl_zero_in.gate_enable && !irq0_sync[1] && !split0
    |=> $stable(cnt0))
    else $error("gated timer 0 counted with pin low");

  a_gate_one: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ctrl_one_in.gate_enable && !irq1_sync[1]
    |=> $stable(cnt1))
    else $error("gated timer 1 counted with pin low");
endmodule : dtc_timer

/* hdl/dtc_pkg.sv */
package dtc_pkg;
  localparam logic [3:0] DTC_MCYC_LAST  = 4'hB;
  localparam logic [4:0] DTC_PRE_LAST   = 5'h1F;
  localparam logic [4:0] DTC_PRE_RESET  = 5'h00;
  localparam logic [7:0] DTC_BYTE_RESET = 8'h00;
  localparam logic [3:0] DTC_DIV_RESET  = 4'h0;

  typedef enum logic [1:0] {
    DTC_MODE_PRE8  = 2'b00,
    DTC_MODE_CNT16 = 2'b01,
    DTC_MODE_AUTO8 = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_type;

  // Per-timer control, one field of the timer mode register
  typedef struct packed {
    logic         gate_enable;
    dtc_mode_type mode;
    logic         run;
  } dtc_ctrl_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtc_count_type;
endpackage : dtc_pkg

/* verification/test_dual_timer_counter_four_mode.sv */
`timescale 1ns/1ps
module test_dual_timer_counter_four_mode;
  logic                   clk_in = 1'b0;
  logic                   rst_in;
  dtc_pkg::dtc_ctrl_type  ctl0;
  dtc_pkg::dtc_ctrl_type  ctl1;
  logic                   split_run;
  logic                   pin0;
  logic                   pin1;
  dtc_pkg::dtc_count_type c0;
  dtc_pkg::dtc_count_type c1;
  logic                   ov0;
  logic                   ov1;
  logic                   ovs;
  int                     error_cnt = 0;
  int                     cmp_count = 0;
  logic [15:0]            s0;
  logic [15:0]            s1;
  int                     i;

  dtc_timer dtc_timer_inst (.clk_in(clk_in), .rst_in(rst_in),
    .ctrl_zero_in(ctl0), .ctrl_one_in(ctl1), .split_run_in(split_run),
    .ext_irq_in_zero(pin0), .ext_irq_in_one(pin1),
    .count_zero_out(c0), .count_one_out(c1), .ovf_zero_out(ov0),
    .ovf_one_out(ov1), .ovf_split_out(ovs));

  always #2.5 clk_in = ~clk_in;

  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic dtc_pkg::dtc_ctrl_type mk(input logic g,
                                               input logic [1:0] m);
    return {g, m, 1'b1};
  endfunction : mk

  task restart(input dtc_pkg::dtc_ctrl_type a, b);
    rst_in = 1'b1;
    ctl0 = a;
    ctl1 = b;
    step(5);
    rst_in = 1'b0;
    step(3);
    s0 = c0;
    s1 = c1;
  endtask : restart

  // Deltas over whole machine cycles so the divider phase does not matter
  task t_modes;
    restart(mk(1'b0, 2'b01), mk(1'b0, 2'b00));
    step(768);
    chk("cnt16", s0 + 16'h0040, c0);
    chk("pre8", s1 + 16'h0200, c1);
    restart(mk(1'b0, 2'b11), mk(1'b0, 2'b11));
    step(120);
    chk("split", s0 + 16'h0A0A, c0);
    chk("stop1", s1, c1);
  endtask : t_modes

  task t_gate;
    pin0 = 1'b0;
    restart(mk(1'b1, 2'b01), mk(1'b1, 2'b01));
    step(120);
    chk("gate low", s0, c0);
    chk("gate high", s1 + 16'h000A, c1);
    pin0 = 1'b1;
    step(3);
    s0 = c0;
    step(120);
    chk("gate open", s0 + 16'h000A, c0);
    ctl1.run = 1'b0;
    s1 = c1;
    step(120);
    chk("stopped", s1, c1);
  endtask : t_gate

  // High half held by its run input first, so the halves wrap apart
  task t_split;
    split_run = 1'b0;
    pin1 = 1'b0;
    restart(mk(1'b0, 2'b11), mk(1'b1, 2'b01));
    step(120);
    chk("split hold", s0 + 16'h000A, c0);
    chk("gate low one", s1, c1);
    split_run = 1'b1;
    for (i = 0; i < 3200 && ov0 !== 1'b1; i++) step(1);
    chk("split low ovf", 16'hF600, c0);
    chk("split high quiet", 16'h0000, {15'h0, ovs});
    for (i = 0; i < 200 && ovs !== 1'b1; i++) step(1);
    chk("split high ovf", 16'h000A, c0);
    chk("split ovf pulse", 16'h0001, {15'h0, ovs});
    step(1);
    chk("split ovf width", 16'h0000, {15'h0, ovs});
    chk("gate still one", s1, c1);
    pin1 = 1'b1;
  endtask : t_split

  task t_auto;
    restart(mk(1'b0, 2'b10), mk(1'b0, 2'b10));
    for (i = 0; i < 3200 && ov0 !== 1'b1; i++) step(1);
    chk("ovf", 16'h0001, {15'h0, ov0});
    chk("ovf one", 16'h0001, {15'h0, ov1});
    chk("ovf time", 16'h0001, {15'h0, i > 3050 && i < 3090});
    chk("reload", 16'h0000, c0);
    chk("reload one", 16'h0000, c1);
    step(1);
    chk("ovf width", 16'h0000, {14'h0, ov0, ov1});
  endtask : t_auto

  task conclude;
    $display("Checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    split_run = 1'b1;
    pin0 = 1'b1;
    pin1 = 1'b1;
    t_modes();
    t_gate();
    t_split();
    t_auto();
    conclude();
  end

  // About 7500 cycles expected; allow four times that
  initial begin
    #150000;
    error_cnt++;
    conclude();
  end
endmodule : test_dual_timer_counter_four_mode
